/* File: acos_scaler.sv */
// The Wishbone register port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
module acos_scaler #(
  parameter int NUM_CH = 8,
  parameter int NUM_SRC = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Internal analog quantities, same clock
  input wire logic signed [15:0] source_value [NUM_SRC],
  input wire logic source_valid,
  // Current output driver codes, microamps
  output acos_pkg::acos_out_s current_output_channel [NUM_CH],
  output logic output_update
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  acos_pkg::acos_cfg_s cfg_q [NUM_CH];
  acos_pkg::acos_state_e state_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic pend_q;
  logic acc;
  logic ch_hit;
  logic stat_hit;
  logic [2:0] ch_idx;
  logic [1:0] reg_idx;
  logic [31:0] rdat;

  assign acc = wb_cyc_i & wb_stb_i & ~ack_q;
  assign ch_idx = wb_adr_i[6:4];
  assign reg_idx = wb_adr_i[3:2];
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  always_comb
  begin
    ch_hit = 1'b0;
    stat_hit = 1'b0;
    if (wb_adr_i[11:8] == acos_pkg::CH_BASE && !wb_adr_i[7] && int'(ch_idx) < NUM_CH)
      ch_hit = 1'b1;
    else if (wb_adr_i == acos_pkg::STAT_ADDR)
      stat_hit = 1'b1;
  end

  always_comb
  begin
    rdat = 32'h0000_0000;
    if (ch_hit)
    begin
      case (reg_idx)
        acos_pkg::CFG_OFS:
        begin
          rdat[acos_pkg::CFG_SRC_LSB +: 3] = cfg_q[ch_idx].src;
          rdat[acos_pkg::CFG_RANGE_LSB +: 2] = cfg_q[ch_idx].range;
        end
        acos_pkg::LOWER_OFS: rdat[15:0] = cfg_q[ch_idx].lower_limit_pu;
        acos_pkg::UPPER_OFS: rdat[15:0] = cfg_q[ch_idx].upper_limit_pu;
        default:
        begin
          rdat[15:0] = current_output_channel[ch_idx].code;
          rdat[acos_pkg::OUT_INHIBIT_BIT] = current_output_channel[ch_idx].inhibit;
        end
      endcase
    end
    else if (stat_hit)
    begin
      rdat[acos_pkg::STAT_BUSY_BIT] = (state_q != acos_pkg::ST_IDLE);
      rdat[acos_pkg::STAT_PEND_BIT] = pend_q;
    end
  end

  // Unmapped addresses are acknowledged and read as zero
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= acc;
      if (acc)
        dat_q <= rdat;
    end
  end

  // ----------------------------------------------------------------
  // Channel settings
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_ch
    always_ff @(posedge clock)
    begin
      if (!reset_n)
      begin
        cfg_q[g].src <= acos_pkg::RST_SRC;
        cfg_q[g].range <= acos_pkg::RST_RANGE;
        cfg_q[g].lower_limit_pu <= acos_pkg::RST_LOWER;
        cfg_q[g].upper_limit_pu <= acos_pkg::RST_UPPER;
      end
      else if (acc && wb_we_i && ch_hit && ch_idx == 3'(g))
      begin
        case (reg_idx)
          acos_pkg::CFG_OFS:
          begin
            if (wb_sel_i[0])
            begin
              cfg_q[g].src <= wb_dat_i[acos_pkg::CFG_SRC_LSB +: 3];
              cfg_q[g].range <= wb_dat_i[acos_pkg::CFG_RANGE_LSB +: 2];
            end
          end
          acos_pkg::LOWER_OFS:
          begin
            if (wb_sel_i[0])
              cfg_q[g].lower_limit_pu[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
              cfg_q[g].lower_limit_pu[15:8] <= wb_dat_i[15:8];
          end
          acos_pkg::UPPER_OFS:
          begin
            if (wb_sel_i[0])
              cfg_q[g].upper_limit_pu[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
              cfg_q[g].upper_limit_pu[15:8] <= wb_dat_i[15:8];
          end
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer: one pass over all channels per sample
  // ----------------------------------------------------------------
  logic [2:0] ch_q;
  logic [5:0] cnt_q;
  logic signed [15:0] snap_q [NUM_SRC];
  logic start;
  logic last_ch;
  logic go_div;

  assign start = (state_q == acos_pkg::ST_IDLE) && pend_q;
  assign last_ch = (int'(ch_q) == NUM_CH - 1);

  // A sample arriving while busy is remembered; set wins over clear
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      pend_q <= 1'b0;
    else
      pend_q <= source_valid | (pend_q & ~start);
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      state_q <= acos_pkg::ST_IDLE;
      ch_q <= 3'h0;
      cnt_q <= 6'h00;
    end
    else
    begin
      case (state_q)
        acos_pkg::ST_IDLE:
        begin
          ch_q <= 3'h0;
          if (pend_q)
            state_q <= acos_pkg::ST_LOAD;
        end
        acos_pkg::ST_LOAD:
        begin
          cnt_q <= 6'h00;
          state_q <= go_div ? acos_pkg::ST_DIV : acos_pkg::ST_STORE;
        end
        acos_pkg::ST_DIV:
        begin
          cnt_q <= cnt_q + 6'h01;
          if (cnt_q == acos_pkg::DIV_STEPS - 6'h01)
            state_q <= acos_pkg::ST_STORE;
        end
        acos_pkg::ST_STORE:
        begin
          ch_q <= ch_q + 3'h1;
          state_q <= last_ch ? acos_pkg::ST_IDLE : acos_pkg::ST_LOAD;
        end
        default: state_q <= acos_pkg::ST_IDLE;
      endcase
    end
  end

  // Snapshot keeps all channels of one pass on the same sample
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      snap_q <= '{default: 16'sh0000};
    else if (start)
      snap_q <= source_value;
  end

  // ----------------------------------------------------------------
  // Datapath: clamp, then restoring divide for the linear segment
  // ----------------------------------------------------------------
  acos_pkg::acos_cfg_s cur;
  logic signed [15:0] x_w;
  logic signed [15:0] imin_w;
  logic signed [15:0] imax_w;
  logic signed [16:0] span_w;
  logic signed [16:0] diff_w;
  logic [15:0] irange_w;
  logic inh_w;
  logic signed [15:0] x_q;
  logic signed [15:0] lo_q;
  logic signed [15:0] hi_q;
  logic signed [15:0] imin_q;
  logic signed [15:0] imax_q;
  logic inh_q;
  logic [31:0] num_q;
  logic [15:0] den_q;
  logic [15:0] rem_q;
  logic [31:0] quo_q;
  logic [16:0] rem_n;
  logic signed [15:0] code_w;

  assign cur = cfg_q[ch_q];
  assign x_w = (int'(cur.src) < NUM_SRC) ? snap_q[cur.src] : 16'sh0000;
  assign span_w = {cur.upper_limit_pu[15], cur.upper_limit_pu}
                - {cur.lower_limit_pu[15], cur.lower_limit_pu};
  assign diff_w = {x_w[15], x_w} - {cur.lower_limit_pu[15], cur.lower_limit_pu};
  assign irange_w = imax_w - imin_w;
  assign go_div = !inh_w && x_w >= cur.lower_limit_pu && x_w <= cur.upper_limit_pu;
  assign rem_n = {rem_q, num_q[31]};

  always_comb
  begin
    imin_w = acos_pkg::I_ZERO;
    imax_w = acos_pkg::I_ZERO;
    case (cur.range)
      acos_pkg::RANGE_BIPOLAR_1MA:
      begin
        imin_w = acos_pkg::I_NEG_1MA;
        imax_w = acos_pkg::I_POS_1MA;
      end
      acos_pkg::RANGE_4_TO_20MA:
      begin
        imin_w = acos_pkg::I_4MA;
        imax_w = acos_pkg::I_20MA;
      end
      acos_pkg::RANGE_0_TO_1MA:
      begin
        imin_w = acos_pkg::I_ZERO;
        imax_w = acos_pkg::I_POS_1MA;
      end
      default: ;
    endcase
  end

  // Unknown range code or missing source counts as a bad setting
  assign inh_w = (span_w < acos_pkg::MIN_SPAN_PU)
               || (cur.range == 2'h3) || (int'(cur.src) >= NUM_SRC);

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      x_q <= 16'sh0000;
      lo_q <= 16'sh0000;
      hi_q <= 16'sh0000;
      imin_q <= 16'sh0000;
      imax_q <= 16'sh0000;
      inh_q <= 1'b1;
      num_q <= 32'h0000_0000;
      den_q <= 16'h0000;
      rem_q <= 16'h0000;
      quo_q <= 32'h0000_0000;
    end
    else if (state_q == acos_pkg::ST_LOAD)
    begin
      x_q <= x_w;
      lo_q <= cur.lower_limit_pu;
      hi_q <= cur.upper_limit_pu;
      imin_q <= imin_w;
      imax_q <= imax_w;
      inh_q <= inh_w;
      num_q <= irange_w * diff_w[15:0];
      den_q <= span_w[15:0];
      rem_q <= 16'h0000;
      quo_q <= 32'h0000_0000;
    end
    else if (state_q == acos_pkg::ST_DIV)
    begin
      num_q <= {num_q[30:0], 1'b0};
      if (rem_n >= {1'b0, den_q})
      begin
        rem_q <= 16'(rem_n - {1'b0, den_q});
        quo_q <= {quo_q[30:0], 1'b1};
      end
      else
      begin
        rem_q <= rem_n[15:0];
        quo_q <= {quo_q[30:0], 1'b0};
      end
    end
  end

  always_comb
  begin
    if (inh_q)
      code_w = acos_pkg::I_ZERO;
    else if (x_q < lo_q)
      code_w = imin_q;
    else if (x_q > hi_q)
      code_w = imax_q;
    else
      code_w = imin_q + quo_q[15:0];
  end

  // ----------------------------------------------------------------
  // Output codes, held between passes
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      current_output_channel <= '{default: '{inhibit: 1'b1, code: 16'sh0000}};
      output_update <= 1'b0;
    end
    else
    begin
      output_update <= (state_q == acos_pkg::ST_STORE) && last_ch;
      if (state_q == acos_pkg::ST_STORE)
        current_output_channel[ch_q] <= '{inhibit: inh_q, code: code_w};
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Counts consecutive divide cycles so the step count can be checked
  logic [6:0] div_run_q;

  always_ff @(posedge clock)
  begin
    if (!reset_n || state_q != acos_pkg::ST_DIV)
      div_run_q <= 7'h00;
    else
      div_run_q <= div_run_q + 7'h01;
  end

  chk_clamp_low: assert property (@(posedge clock) disable iff (!reset_n)
    (state_q == acos_pkg::ST_STORE && !inh_q && x_q < lo_q)
    |=> current_output_channel[$past(ch_q)].code == $past(imin_q))
    else $error("below lower limit did not give range minimum");

  chk_clamp_high: assert property (@(posedge clock) disable iff (!reset_n)
    (state_q == acos_pkg::ST_STORE && !inh_q && x_q > hi_q)
    |=> current_output_channel[$past(ch_q)].code == $past(imax_q))
    else $error("above upper limit did not give range maximum");

  chk_scale_bounds: assert property (@(posedge clock) disable iff (!reset_n)
    (state_q == acos_pkg::ST_STORE && !inh_q && x_q >= lo_q && x_q <= hi_q)
    |-> (code_w >= imin_q && code_w <= imax_q && (x_q != lo_q || code_w == imin_q)))
    else $error("scaled code outside range");

  chk_div_length: assert property (@(posedge clock) disable iff (!reset_n)
    (state_q == acos_pkg::ST_LOAD && go_div)
    |=> state_q == acos_pkg::ST_DIV
        ##32 (state_q == acos_pkg::ST_STORE && div_run_q == 7'h20))
    else $error("divide did not take thirty-two steps");

  chk_span_inhibit: assert property (@(posedge clock) disable iff (!reset_n)
    (state_q == acos_pkg::ST_LOAD && span_w < acos_pkg::MIN_SPAN_PU)
    |=> (inh_q && state_q == acos_pkg::ST_STORE && code_w == acos_pkg::I_ZERO))
    else $error("narrow span did not inhibit output");

  chk_source_pick: assert property (@(posedge clock) disable iff (!reset_n)
    (state_q == acos_pkg::ST_LOAD && int'(cur.src) < NUM_SRC)
    |=> x_q == $past(snap_q[cur.src]))
    else $error("wrong source taken");

  chk_range_ends: assert property (@(posedge clock) disable iff (!reset_n)
    (state_q == acos_pkg::ST_LOAD && cur.range == acos_pkg::RANGE_4_TO_20MA)
    |=> (imin_q == acos_pkg::I_4MA && imax_q == acos_pkg::I_20MA))
    else $error("four to twenty range ends wrong");

  chk_lower_write: assert property (@(posedge clock) disable iff (!reset_n)
    (acc && wb_we_i && ch_hit && reg_idx == acos_pkg::LOWER_OFS && wb_sel_i[1:0] == 2'h3)
    |=> cfg_q[$past(ch_idx)].lower_limit_pu == $past(wb_dat_i[15:0]))
    else $error("lower limit write lost");

  chk_upper_write: assert property (@(posedge clock) disable iff (!reset_n)
    (acc && wb_we_i && ch_hit && reg_idx == acos_pkg::UPPER_OFS && wb_sel_i[1:0] == 2'h3)
    |=> cfg_q[$past(ch_idx)].upper_limit_pu == $past(wb_dat_i[15:0]))
    else $error("upper limit write lost");

  chk_reset_set: assert property (@(posedge clock)
    !reset_n |=> (cfg_q[NUM_CH-1].upper_limit_pu == acos_pkg::RST_UPPER
                  && cfg_q[NUM_CH-1].range == acos_pkg::RST_RANGE))
    else $error("channel settings not created at reset");

  chk_sample_start: assert property (@(posedge clock) disable iff (!reset_n)
    (state_q == acos_pkg::ST_IDLE && source_valid) |=> ##1 state_q == acos_pkg::ST_LOAD)
    else $error("sample did not start a pass");

  chk_out_hold: assert property (@(posedge clock) disable iff (!reset_n)
    (state_q != acos_pkg::ST_STORE || ch_q != 3'h0) |=> $stable(current_output_channel[0]))
    else $error("output changed between samples");

endmodule
`default_nettype wire

/* File: acos_pkg.sv */
`default_nettype none
package acos_pkg;

  // ----------------------------------------------------------------
  // Widths and fixed-point format
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int PU_FRAC = 12;
  localparam int ADR_W = 12;
  localparam int SRC_W = 3;
  localparam logic [5:0] DIV_STEPS = 6'h20;

  // Smallest usable limit span, 0.1 pu in signed Q4.12 (409.6 rounds up to 410)
  localparam logic signed [16:0] MIN_SPAN_PU = 17'sh0_019a;

  // ----------------------------------------------------------------
  // Output ranges and their end currents in microamps
  // ----------------------------------------------------------------
  localparam logic [1:0] RANGE_BIPOLAR_1MA = 2'h0;
  localparam logic [1:0] RANGE_4_TO_20MA = 2'h1;
  localparam logic [1:0] RANGE_0_TO_1MA = 2'h2;
  localparam logic signed [15:0] I_NEG_1MA = -16'sh03e8;
  localparam logic signed [15:0] I_POS_1MA = 16'sh03e8;
  localparam logic signed [15:0] I_4MA = 16'sh0fa0;
  localparam logic signed [15:0] I_20MA = 16'sh4e20;
  localparam logic signed [15:0] I_ZERO = 16'sh0000;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] STAT_ADDR = 12'h000;
  localparam logic [3:0] CH_BASE = 4'h1;
  localparam logic [1:0] CFG_OFS = 2'h0;
  localparam logic [1:0] LOWER_OFS = 2'h1;
  localparam logic [1:0] UPPER_OFS = 2'h2;
  localparam logic [1:0] OUT_OFS = 2'h3;
  localparam int CFG_SRC_LSB = 0;
  localparam int CFG_RANGE_LSB = 4;
  localparam int OUT_INHIBIT_BIT = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_PEND_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values of each channel's setting set
  // ----------------------------------------------------------------
  localparam logic [2:0] RST_SRC = 3'h0;
  localparam logic [1:0] RST_RANGE = RANGE_4_TO_20MA;
  localparam logic signed [15:0] RST_LOWER = 16'sh0000;
  localparam logic signed [15:0] RST_UPPER = 16'sh1000;

  typedef struct packed {
    logic [2:0] src;
    logic [1:0] range;
    logic signed [15:0] lower_limit_pu;
    logic signed [15:0] upper_limit_pu;
  } acos_cfg_s;

  typedef struct packed {
    logic inhibit;
    logic signed [15:0] code;
  } acos_out_s;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LOAD = 4'b0010,
    ST_DIV = 4'b0100,
    ST_STORE = 4'b1000
  } acos_state_e;

endpackage
`default_nettype wire

/* File: acos_scaler_note_end.sv */
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

/* File: acos_driver_model.sv */
`timescale 1ns/10ps
`default_nettype none
module acos_driver_model #(
  parameter int NUM_CH = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Codes from the scaler
  input wire acos_pkg::acos_out_s current_output_channel [NUM_CH],
  input wire logic output_update,
  // Codes held at the loop terminals
  output logic [16:0] held_q [NUM_CH]
);
  // Latch a whole set per pass so the loop never mixes two samples
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        held_q[c] <= 17'h1_0000;
      end
    end
    else if (output_update)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        held_q[c] <= current_output_channel[c];
      end
    end
  end
endmodule
`default_nettype wire

/* File: test_analog_current_output_scaler.sv */
`timescale 1ns/10ps
`default_nettype none
module test_analog_current_output_scaler;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic signed [15:0] source_value [8];
  logic source_valid = 1'b0;
  acos_pkg::acos_out_s current_output_channel [8];
  logic output_update;
  logic [16:0] held [8];
  logic [15:0] lfsr = 16'hc8fa;
  logic [31:0] rd;
  logic [31:0] exp_v;
  int failures = 0;
  int checked = 0;
  int rng_m [8];
  int lo_m [8];
  int hi_m [8];
  int src_m [8];
  int sv [8];
  int span;

  always #4 clock = ~clock;

  acos_scaler #(.NUM_CH(8), .NUM_SRC(8)) acos_scaler_i (
    .clock(clock), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .source_value(source_value),
    .source_valid(source_valid), .current_output_channel(current_output_channel),
    .output_update(output_update)
  );
  acos_driver_model #(.NUM_CH(8)) acos_driver_model_i (
    .clock(clock), .reset_n(reset_n), .current_output_channel(current_output_channel),
    .output_update(output_update), .held_q(held)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic int rnd(input int modulo);
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return int'(lfsr) % modulo;
  endfunction

  function automatic logic [11:0] ch_adr(input int c, input int ofs);
    return 12'(256 + 16 * c + 4 * ofs);
  endfunction

  // Reference transfer: clamp, then scale with a floored quotient
  function automatic logic [31:0] model_out(input int rng, input int lo, input int hi, input int x);
    int imin;
    int imax;
    int y;
    imin = (rng == 0) ? -1000 : (rng == 1) ? 4000 : 0;
    imax = (rng == 0) ? 1000 : (rng == 1) ? 20000 : 1000;
    if (rng == 3 || hi - lo < 410)
      return 32'h0001_0000;
    if (x < lo)
      y = imin;
    else if (x > hi)
      y = imax;
    else
      y = imin + (imax - imin) * (x - lo) / (hi - lo);
    return {16'h0000, 16'(y)};
  endfunction

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Classic single cycle; the answer is taken only at the edge that sees ack
  task automatic wb_xfer(input logic we, input logic [11:0] adr, input logic [31:0] wdat,
                         output logic [31:0] rdat);
    int n;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wdat;
    wb_sel_i <= 4'hf;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1)
    begin
      failures++;
      final_report();
    end
  endtask

  task automatic wait_update();
    int n;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (output_update !== 1'b1 && n < 1000);
    if (output_update !== 1'b1)
    begin
      failures++;
      final_report();
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    for (int i = 0; i < 8; i++)
    begin
      source_value[i] = 16'sh0000;
    end
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    for (int c = 0; c < 8; c++)
    begin
      check({15'h0000, current_output_channel[c]}, 32'h0001_0000);
      wb_xfer(1'b0, ch_adr(c, 0), 32'h0000_0000, rd);
      check(rd & 32'h0000_0037, 32'h0000_0010);
      wb_xfer(1'b0, ch_adr(c, 1), 32'h0000_0000, rd);
      check(rd, 32'h0000_0000);
      wb_xfer(1'b0, ch_adr(c, 2), 32'h0000_0000, rd);
      check(rd, 32'h0000_1000);
    end
    wb_xfer(1'b1, 12'h0f0, 32'hffff_ffff, rd);
    wb_xfer(1'b0, 12'h0f0, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000);
    for (int r = 0; r < 8; r++)
    begin
      // Spans of 409 and 410 straddle the inhibit threshold in rounds 0, 1, 4 and 5, where neither has range code 3
      for (int c = 0; c < 8; c++)
      begin
        rng_m[c] = (c + r) % 4;
        src_m[c] = rnd(8);
        lo_m[c] = rnd(8192) - 4096;
        span = (c == 0) ? 409 : (c == 1) ? 410 : rnd(4096);
        hi_m[c] = lo_m[c] + span;
        wb_xfer(1'b1, ch_adr(c, 0), 32'(rng_m[c] * 16 + src_m[c]), rd);
        wb_xfer(1'b1, ch_adr(c, 1), 32'(lo_m[c]) & 32'h0000_ffff, rd);
        wb_xfer(1'b1, ch_adr(c, 2), 32'(hi_m[c]) & 32'h0000_ffff, rd);
        wb_xfer(1'b0, ch_adr(c, 0), 32'h0000_0000, rd);
        check(rd & 32'h0000_0037, 32'(rng_m[c] * 16 + src_m[c]));
        wb_xfer(1'b0, ch_adr(c, 1), 32'h0000_0000, rd);
        check(rd, 32'(lo_m[c]) & 32'h0000_ffff);
        wb_xfer(1'b0, ch_adr(c, 2), 32'h0000_0000, rd);
        check(rd, 32'(hi_m[c]) & 32'h0000_ffff);
      end
      @(posedge clock);
      for (int i = 0; i < 8; i++)
      begin
        sv[i] = rnd(16384) - 8192;
        source_value[i] <= 16'(sv[i]);
      end
      source_valid <= 1'b1;
      @(posedge clock);
      source_valid <= 1'b0;
      // The pass is under way by the time this read is taken
      wb_xfer(1'b0, acos_pkg::STAT_ADDR, 32'h0000_0000, rd);
      check(rd, 32'h0000_0001);
      wait_update();
      repeat (3) @(posedge clock);
      // New values without a valid pulse must not disturb the held codes
      for (int i = 0; i < 8; i++)
      begin
        source_value[i] <= 16'(rnd(16384) - 8192);
      end
      // Let the new values sit a few cycles; the sequencer must stay idle
      wb_xfer(1'b0, acos_pkg::STAT_ADDR, 32'h0000_0000, rd);
      check(rd, 32'h0000_0000);
      for (int c = 0; c < 8; c++)
      begin
        exp_v = model_out(rng_m[c], lo_m[c], hi_m[c], sv[src_m[c]]);
        check({15'h0000, current_output_channel[c]}, exp_v);
        check({15'h0000, held[c]}, exp_v);
        wb_xfer(1'b0, ch_adr(c, 3), 32'h0000_0000, rd);
        check(rd & 32'h0001_ffff, exp_v);
      end
    end
    final_report();
  end
endmodule
`default_nettype wire
